// >>> rgb_panel_regs.vh
`ifndef RGB_PANEL_REGS_VH
`define RGB_PANEL_REGS_VH

// Frame geometry
`define H_ACTIVE 10'd480
`define V_ACTIVE 10'd800

// Pixel bus widths
`define BUS_WIDTH 24
`define FIFO_WIDTH 26
`define FIFO_DEPTH 8
`define FIFO_ADDR 3

// Bus width modes held in config register 0, bits [1:0]
`define MODE_POS 1:0
`define MODE_24 2'h0
`define MODE_18 2'h1
`define MODE_16 2'h2

// Serial configuration frame: read flag, 7 address bits, 8 data bits
`define CFG_FRAME_BITS 5'd16
`define CFG_HDR_BITS 5'd8
`define CFG_READ_POS 15
`define CFG_ADDR_POS 14:8
`define CFG_DATA_POS 7:0
`define CFG_REG_COUNT 8
`define CFG_REG_AW 3
`define CFG_RESET_VAL 8'h00

// Synchroniser width: all pins sampled by sys_clk
`define SYNC_WIDTH 32

`endif

// >>> pixel_fifo.v
`timescale 1ns/100ps
`default_nettype none

// Small pixel FIFO with a registered read stage
module pixel_fifo #(
  parameter WIDTH = 26,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire rst,
  input wire clr,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output reg out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage array, no reset needed
  reg [AW-1:0] wr_ptr_reg; // Next slot to write
  reg [AW-1:0] rd_ptr_reg; // Next slot to read
  reg [AW:0] count_reg; // Words held in the array
  wire push;
  wire pop;

  // Full stops the writer; the output stage stalls when the reader stalls
  assign in_ready = (count_reg != DEPTH[AW:0]);
  assign push = in_valid & in_ready;
  assign pop = (count_reg != {(AW+1){1'b0}}) & (~out_valid | out_ready);

  // Array write
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers, fill level and output register
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end else if (clr) begin
      // Pin reset drops whatever is in flight
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
        out_data <= mem[rd_ptr_reg];
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      // Level moves only when exactly one side acts
      if (push & ~pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop & ~push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule // pixel_fifo

`default_nettype wire

// >>> rgb_panel_port.v
`timescale 1ns/100ps
`default_nettype none
`include "rgb_panel_regs.vh"

module rgb_panel_port (
  input wire sys_clk,
  input wire rst,
  input wire panel_reset_n,
  input wire dot_clk,
  input wire frame_sync_n,
  input wire line_sync_n,
  input wire pixel_data_valid_n,
  input wire [23:0] pixel_data_bus,
  input wire cfg_select_n,
  input wire cfg_clk,
  input wire cfg_data_in,
  output reg cfg_data_out,
  output reg cfg_data_out_oe,
  output wire pix_valid,
  input wire pix_ready,
  output wire [23:0] pix_data,
  output wire pix_frame_first,
  output wire pix_line_first,
  output reg pix_overflow,
  output reg frame_done,
  output reg [1:0] bus_width_mode
);

  // Expand a narrower bus to 24-bit colour, top bits copied into the gap
  function [23:0] expand_pixel;
    input [1:0] mode;
    input [23:0] bus;
    begin
      case (mode)
        `MODE_18: expand_pixel = {bus[17:12], bus[17:16], bus[11:6], bus[11:10],
                                  bus[5:0], bus[5:4]};
        `MODE_16: expand_pixel = {bus[15:11], bus[15:13], bus[10:5], bus[10:9],
                                  bus[4:0], bus[4:2]};
        default: expand_pixel = bus;
      endcase
    end
  endfunction

  wire [`SYNC_WIDTH-1:0] pins_raw; // Every pin from the outside world
  reg [`SYNC_WIDTH-1:0] sync1_reg; // First stage, read only by second
  reg [`SYNC_WIDTH-1:0] sync2_reg; // Safe copy of the pins
  reg dot_clk_d_reg; // Last seen dot clock level
  reg cfg_clk_d_reg; // Last seen serial clock level
  reg frame_sync_d_reg; // Sync levels at previous dot edge
  reg line_sync_d_reg;
  reg in_reset_reg; // Reset pin held low
  reg [9:0] col_reg; // Pixel index within line
  reg [9:0] row_reg; // Line index within frame
  reg frame_first_reg; // Next accepted pixel opens a frame
  reg line_first_reg; // Next accepted pixel opens a line
  reg seen_line_reg; // A line has started in this frame
  reg [7:0] cfg_regs [0:`CFG_REG_COUNT-1]; // Configuration bytes
  reg [15:0] cfg_shift_reg; // Serial input shift
  reg [4:0] cfg_bits_reg; // Bits received this frame
  reg [7:0] cfg_out_reg; // Read-back byte being shifted out
  reg fifo_in_valid_reg;
  reg [`FIFO_WIDTH-1:0] fifo_in_data_reg;
  wire fifo_in_ready;
  wire dot_rise;
  wire cfg_rise;
  wire cfg_fall;
  wire frame_sync_s;
  wire line_sync_s;
  wire valid_n_s;
  wire [23:0] bus_s;
  wire cfg_select_n_s;
  wire cfg_data_s;
  wire reset_n_s;
  wire frame_start;
  wire line_start;
  wire [`CFG_REG_AW-1:0] cfg_addr;
  integer i;

  assign pins_raw = {panel_reset_n, dot_clk, frame_sync_n, line_sync_n, pixel_data_valid_n,
                     pixel_data_bus, cfg_select_n, cfg_clk, cfg_data_in};

  // Two flip-flop synchroniser for every pin, one process so each stage has one driver
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      // Reset pin stage starts low, so leaving rst never looks like a pin release
      sync1_reg <= {1'b0, {(`SYNC_WIDTH-1){1'b1}}};
      sync2_reg <= {1'b0, {(`SYNC_WIDTH-1){1'b1}}};
    end else begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
    end
  end

  assign reset_n_s = sync2_reg[31];
  assign frame_sync_s = sync2_reg[29];
  assign line_sync_s = sync2_reg[28];
  assign valid_n_s = sync2_reg[27];
  assign bus_s = sync2_reg[26:3];
  assign cfg_select_n_s = sync2_reg[2];
  assign cfg_data_s = sync2_reg[0];

  // Edges are found on the synchronised copies only
  assign dot_rise = sync2_reg[30] & ~dot_clk_d_reg;
  assign cfg_rise = sync2_reg[1] & ~cfg_clk_d_reg;
  assign cfg_fall = ~sync2_reg[1] & cfg_clk_d_reg;
  // Syncs are taken as active low; a falling level marks the start
  assign frame_start = dot_rise & ~frame_sync_s & frame_sync_d_reg;
  assign line_start = dot_rise & ~line_sync_s & line_sync_d_reg;
  assign cfg_addr = cfg_shift_reg[`CFG_REG_AW-1:0];

  // Edge history and reset pin level
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dot_clk_d_reg <= 1'b1;
      cfg_clk_d_reg <= 1'b1;
      in_reset_reg <= 1'b1;
    end else begin
      dot_clk_d_reg <= sync2_reg[30];
      cfg_clk_d_reg <= sync2_reg[1];
      in_reset_reg <= ~reset_n_s;
    end
  end

  // Pixel capture, one decision per dot clock rising edge
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      frame_sync_d_reg <= 1'b1;
      line_sync_d_reg <= 1'b1;
      col_reg <= 10'h000;
      row_reg <= 10'h000;
      frame_first_reg <= 1'b0;
      line_first_reg <= 1'b0;
      seen_line_reg <= 1'b0;
      fifo_in_valid_reg <= 1'b0;
      fifo_in_data_reg <= {`FIFO_WIDTH{1'b0}};
      pix_overflow <= 1'b0;
      frame_done <= 1'b0;
    end else if (in_reset_reg) begin
      // Everything but fifo_in_data_reg back to its starting point while the pin is low
      frame_sync_d_reg <= 1'b1;
      line_sync_d_reg <= 1'b1;
      col_reg <= 10'h000;
      row_reg <= 10'h000;
      frame_first_reg <= 1'b0;
      line_first_reg <= 1'b0;
      seen_line_reg <= 1'b0;
      fifo_in_valid_reg <= 1'b0;
      pix_overflow <= 1'b0;
      frame_done <= 1'b0;
    end else begin
      frame_done <= 1'b0;
      // Hold the word until the FIFO takes it
      if (fifo_in_ready) begin
        fifo_in_valid_reg <= 1'b0;
      end
      if (dot_rise) begin
        frame_sync_d_reg <= frame_sync_s;
        line_sync_d_reg <= line_sync_s;
      end
      if (frame_start) begin
        // New frame: counters back to the top left
        row_reg <= 10'h000;
        col_reg <= 10'h000;
        frame_first_reg <= 1'b1;
        line_first_reg <= 1'b1;
        seen_line_reg <= 1'b0;
        pix_overflow <= 1'b0;
      end else if (line_start) begin
        // First line after the frame sync keeps row zero
        col_reg <= 10'h000;
        line_first_reg <= 1'b1;
        seen_line_reg <= 1'b1;
        if (seen_line_reg && row_reg < `V_ACTIVE) begin
          row_reg <= row_reg + 10'h001;
        end
      end else if (dot_rise && !valid_n_s && frame_sync_s && line_sync_s) begin
        // Only enabled pixels outside sync intervals, inside the frame, are kept
        if (col_reg < `H_ACTIVE && row_reg < `V_ACTIVE) begin
          if (fifo_in_valid_reg && !fifo_in_ready) begin
            // Previous word still stuck: this pixel is lost
            pix_overflow <= 1'b1;
          end else begin
            fifo_in_valid_reg <= 1'b1;
            fifo_in_data_reg <= {frame_first_reg, line_first_reg,
                                 expand_pixel(bus_width_mode, bus_s)};
          end
          frame_first_reg <= 1'b0;
          line_first_reg <= 1'b0;
          col_reg <= col_reg + 10'h001;
          if (col_reg == `H_ACTIVE - 10'h001 && row_reg == `V_ACTIVE - 10'h001) begin
            frame_done <= 1'b1;
          end
        end
      end
    end
  end

  // Serial configuration: sample on rising, shift out on falling serial clock
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg_shift_reg <= 16'h0000;
      cfg_bits_reg <= 5'h00;
      cfg_out_reg <= 8'h00;
      cfg_data_out <= 1'b0;
      cfg_data_out_oe <= 1'b0;
      bus_width_mode <= `MODE_24;
      for (i = 0; i < `CFG_REG_COUNT; i = i + 1) begin
        cfg_regs[i] <= `CFG_RESET_VAL;
      end
    end else if (in_reset_reg || cfg_select_n_s) begin
      // Deselected: clock and data are ignored, the frame restarts
      cfg_bits_reg <= 5'h00;
      cfg_data_out <= 1'b0;
      cfg_data_out_oe <= 1'b0;
      if (in_reset_reg) begin
        bus_width_mode <= `MODE_24;
        for (i = 0; i < `CFG_REG_COUNT; i = i + 1) begin
          cfg_regs[i] <= `CFG_RESET_VAL;
        end
      end
    end else begin
      if (cfg_rise && cfg_bits_reg < `CFG_FRAME_BITS) begin
        cfg_shift_reg <= {cfg_shift_reg[14:0], cfg_data_s};
        cfg_bits_reg <= cfg_bits_reg + 5'h01;
        if (cfg_bits_reg == `CFG_HDR_BITS - 5'h01 && cfg_shift_reg[6]) begin
          // Read header complete: fetch the addressed byte
          cfg_out_reg <= cfg_regs[{cfg_shift_reg[1:0], cfg_data_s}];
        end
        if (cfg_bits_reg == `CFG_FRAME_BITS - 5'h01 && !cfg_shift_reg[14]) begin
          cfg_regs[cfg_shift_reg[9:7]] <= {cfg_shift_reg[6:0], cfg_data_s};
          if (cfg_shift_reg[9:7] == 3'h0) begin
            bus_width_mode <= cfg_shift_reg[0] ? `MODE_16 :
                              (cfg_data_s ? `MODE_18 : `MODE_24);
          end
        end
      end
      if (cfg_fall && cfg_bits_reg >= `CFG_HDR_BITS && cfg_bits_reg < `CFG_FRAME_BITS
          && cfg_shift_reg[cfg_bits_reg[3:0] - 4'h1]) begin
        // Read data phase: MSB first on the dedicated output
        cfg_data_out <= cfg_out_reg[7];
        cfg_out_reg <= {cfg_out_reg[6:0], 1'b0};
        cfg_data_out_oe <= 1'b1;
      end else if (cfg_fall && cfg_bits_reg == `CFG_FRAME_BITS) begin
        cfg_data_out <= 1'b0;
        cfg_data_out_oe <= 1'b0;
      end
    end
  end

  // Pixel FIFO between capture and the display side
  pixel_fifo #(
    .WIDTH(`FIFO_WIDTH),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_ADDR)
  ) u_fifo (
    .clk(sys_clk),
    .rst(rst),
    .clr(in_reset_reg),
    .in_valid(fifo_in_valid_reg),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data_reg),
    .out_valid(pix_valid),
    .out_ready(pix_ready),
    .out_data({pix_frame_first, pix_line_first, pix_data})
  );

endmodule // rgb_panel_port

`default_nettype wire

// >>> rgb_panel_port_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// Pin and stream checks
module rgb_panel_port_monitor (
  input wire sys_clk,
  input wire rst,
  input wire panel_reset_n,
  input wire frame_sync_n,
  input wire pixel_data_valid_n,
  input wire cfg_select_n,
  input wire cfg_data_out,
  input wire cfg_data_out_oe,
  input wire pix_valid,
  input wire pix_ready,
  input wire [23:0] pix_data,
  input wire pix_frame_first,
  input wire pix_line_first,
  input wire pix_overflow,
  input wire frame_done,
  input wire [1:0] bus_width_mode
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Pins idle long enough to cover the synchroniser delay
  sequence s_quiet;
    (frame_sync_n && panel_reset_n) [*6];
  endsequence
  sequence s_unselected;
    (cfg_select_n && panel_reset_n) [*6];
  endsequence
  property p_reset_mode;
    (!panel_reset_n) [*5] |-> bus_width_mode == 2'h0 && !pix_valid;
  endproperty
  a_reset_mode: assert property (p_reset_mode)
    else $error("state kept during reset pin");
  property p_sel_idle;
    cfg_select_n [*6] |-> !cfg_data_out_oe && !cfg_data_out;
  endproperty
  a_sel_idle: assert property (p_sel_idle)
    else $error("serial output active while unselected");
  property p_mode_keep;
    s_unselected |=> $stable(bus_width_mode);
  endproperty
  a_mode_keep: assert property (p_mode_keep)
    else $error("mode changed while unselected");
  property p_hold;
    pix_valid && !pix_ready && panel_reset_n |=> pix_valid && $stable(pix_data);
  endproperty
  a_hold: assert property (p_hold)
    else $error("pixel word not held while stalled");
  property p_no_capture;
    (pixel_data_valid_n && !pix_valid) [*8] |=> !pix_valid;
  endproperty
  a_no_capture: assert property (p_no_capture)
    else $error("pixel appeared while enable inactive");
  property p_flags;
    pix_valid && pix_frame_first |-> pix_line_first;
  endproperty
  a_flags: assert property (p_flags)
    else $error("frame first without line first");
  property p_ovf_sticky;
    s_quiet ##0 pix_overflow |=> pix_overflow;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky)
    else $error("overflow lost without frame start");
  property p_done_pulse;
    frame_done |=> !frame_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("frame done longer than one cycle");
endmodule // rgb_panel_port_monitor
bind rgb_panel_port rgb_panel_port_monitor u_mon (.sys_clk(sys_clk), .rst(rst),
  .panel_reset_n(panel_reset_n), .frame_sync_n(frame_sync_n),
  .pixel_data_valid_n(pixel_data_valid_n), .cfg_select_n(cfg_select_n),
  .cfg_data_out(cfg_data_out), .cfg_data_out_oe(cfg_data_out_oe), .pix_valid(pix_valid),
  .pix_ready(pix_ready), .pix_data(pix_data), .pix_frame_first(pix_frame_first),
  .pix_line_first(pix_line_first), .pix_overflow(pix_overflow), .frame_done(frame_done),
  .bus_width_mode(bus_width_mode));
`default_nettype wire

// >>> host_model.sv
`timescale 1ns/100ps
`default_nettype none
// Host controller: pixel pins and serial config pins
module host_model (
  input wire sys_clk,
  input wire cfg_data_out,
  output logic panel_reset_n,
  output logic dot_clk,
  output logic frame_sync_n,
  output logic line_sync_n,
  output logic pixel_data_valid_n,
  output logic [23:0] pixel_data_bus,
  output logic cfg_select_n,
  output logic cfg_clk,
  output logic cfg_data_in
);
  // Idle levels at time zero; dot clock stands still between frames
  initial begin
    panel_reset_n = 1'b0;
    dot_clk = 1'b1;
    frame_sync_n = 1'b1;
    line_sync_n = 1'b1;
    pixel_data_valid_n = 1'b1;
    pixel_data_bus = 24'h000000;
    cfg_select_n = 1'b1;
    cfg_clk = 1'b0;
    cfg_data_in = 1'b0;
  end
  task w(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Reset pulse before any transfer
  task preset();
    panel_reset_n <= 1'b0;
    w(6);
    panel_reset_n <= 1'b1;
    w(6);
  endtask
  // One 800 ns dot period; unused bus toggles so stale data never looks valid
  task dot(input [23:0] d, input vn, input fs, input ls);
    @(posedge sys_clk);
    dot_clk <= 1'b0;
    pixel_data_bus <= vn ? ~pixel_data_bus : d;
    pixel_data_valid_n <= vn;
    frame_sync_n <= fs;
    line_sync_n <= ls;
    w(4);
    dot_clk <= 1'b1;
    w(3);
  endtask
  // 16-bit serial frame, MSB first; read bits sampled late in the low half
  task cfg(input [15:0] f, input sel_n, output [7:0] rd);
    cfg_select_n <= sel_n;
    for (int i = 15; i >= 0; i--) begin
      w(1);
      cfg_clk <= 1'b0;
      cfg_data_in <= f[i];
      w(6);
      if (i < 8) rd[i] = cfg_data_out;
      cfg_clk <= 1'b1;
      w(5);
    end
    w(4);
    cfg_select_n <= 1'b1;
    cfg_data_in <= ~cfg_data_in;
    // Select stays high long enough for the port to see the frame end
    w(4);
  endtask
endmodule // host_model
`default_nettype wire

// >>> rgb_panel_port_tb.sv
`timescale 1ns/100ps
`default_nettype none
module rgb_panel_port_tb;
  logic sys_clk = 0, rst = 1, pix_ready = 0, stall = 0, chk_on = 1, f_pend, l_pend;
  wire prn, dclk, fs_n, ls_n, dv_n, sel_n, sclk, sdi, sdo, sdo_oe, pv, pff, plf, povf, fdone;
  wire [23:0] bus, pdat;
  wire [1:0] mode;
  int fail_count = 0, num_checks = 0;
  int oe_cnt = 0, done_cnt = 0, o;
  logic [15:0] lfsr = 16'h004C, rl = 16'h004C;
  logic [25:0] expq[$], e;
  logic [7:0] rd;
  logic [1:0] mode_m = 2'h0;
  initial forever #50 sys_clk = ~sys_clk;
  host_model u_h (.sys_clk(sys_clk), .cfg_data_out(sdo), .panel_reset_n(prn), .dot_clk(dclk),
    .frame_sync_n(fs_n), .line_sync_n(ls_n), .pixel_data_valid_n(dv_n), .pixel_data_bus(bus),
    .cfg_select_n(sel_n), .cfg_clk(sclk), .cfg_data_in(sdi));
  rgb_panel_port dut (.sys_clk(sys_clk), .rst(rst), .panel_reset_n(prn), .dot_clk(dclk),
    .frame_sync_n(fs_n), .line_sync_n(ls_n), .pixel_data_valid_n(dv_n), .pixel_data_bus(bus),
    .cfg_select_n(sel_n), .cfg_clk(sclk), .cfg_data_in(sdi), .cfg_data_out(sdo),
    .cfg_data_out_oe(sdo_oe), .pix_valid(pv), .pix_ready(pix_ready), .pix_data(pdat),
    .pix_frame_first(pff), .pix_line_first(plf), .pix_overflow(povf), .frame_done(fdone),
    .bus_width_mode(mode));
  function automatic logic [15:0] nx(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Narrow modes copy the top bits of each colour into its low bits
  function automatic logic [23:0] x24(logic [1:0] m, logic [23:0] d);
    if (m == 2'h0) return d;
    if (m == 2'h1) return {d[17:12], d[17:16], d[11:6], d[11:10], d[5:0], d[5:4]};
    return {d[15:11], d[15:13], d[10:5], d[10:9], d[4:0], d[4:2]};
  endfunction
  task chk(string nm, logic [31:0] x, logic [31:0] s);
    num_checks++;
    if (x !== s) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, x, s);
    end
  endtask
  task end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Consumer with random stalls, compared with the queued model
  always @(posedge sys_clk) begin
    rl <= nx(rl);
    pix_ready <= !stall && (rl[0] | rl[2]);
    if (sdo_oe === 1'b1) oe_cnt++;
    if (fdone === 1'b1) done_cnt++;
    if (chk_on && pv === 1'b1 && pix_ready === 1'b1) begin
      if (expq.size() == 0) chk("extra pixel", 0, 1);
      else begin
        e = expq.pop_front();
        chk("pixel", e, {pff, plf, pdat});
      end
    end
  end
  // Frame sync, line sync, pixels with random enable, then a second line
  task frame(input int n);
    u_h.dot(24'h000000, 1'b1, 1'b0, 1'b1);
    f_pend = 1;
    for (int l = 0; l < 2; l++) begin
      u_h.dot(24'h000000, 1'b1, 1'b1, 1'b0);
      l_pend = 1;
      for (int p = 0; p < n; p++) begin
        lfsr = nx(lfsr);
        u_h.dot({lfsr[9:2], lfsr}, lfsr[5] & lfsr[1], 1'b1, 1'b1);
        if (!(lfsr[5] & lfsr[1])) begin
          expq.push_back({f_pend, l_pend, x24(mode_m, {lfsr[9:2], lfsr})});
          f_pend = 0;
          l_pend = 0;
        end
      end
    end
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    u_h.preset();
    u_h.cfg(16'h0001, 1'b1, rd);
    chk("mode unselected", 2'h0, mode);
    for (int m = 0; m < 4; m++) begin
      o = oe_cnt;
      u_h.cfg({8'h00, 6'h00, m[1:0]}, 1'b0, rd);
      mode_m = (m == 3) ? 2'h2 : m[1:0];
      chk("mode", mode_m, mode);
      chk("enable on write", 0, oe_cnt - o);
      o = oe_cnt;
      u_h.cfg(16'h8000, 1'b0, rd);
      chk("readback", m, rd);
      chk("enable on read", 1, oe_cnt > o);
      frame(10);
      for (int t = 0; t < 400 && expq.size() > 0; t++) @(posedge sys_clk);
      chk("queue drained", 0, expq.size());
    end
    // Full frame: 800 line starts, pixels on the last line only, one extra refused
    u_h.dot(24'h000000, 1'b1, 1'b0, 1'b1);
    repeat (800) begin
      u_h.dot(24'h000000, 1'b1, 1'b1, 1'b0);
      u_h.dot(24'h000000, 1'b1, 1'b1, 1'b1);
    end
    for (int p = 0; p < 481; p++) begin
      lfsr = nx(lfsr);
      u_h.dot({lfsr[7:0], lfsr}, 1'b0, 1'b1, 1'b1);
      if (p < 480) expq.push_back({p == 0, p == 0, x24(mode_m, {lfsr[7:0], lfsr})});
    end
    for (int t = 0; t < 400 && expq.size() > 0; t++) @(posedge sys_clk);
    chk("queue drained full frame", 0, expq.size());
    chk("frame done pulses", 1, done_cnt);
    stall = 1;
    u_h.dot(24'h000000, 1'b1, 1'b0, 1'b1);
    u_h.dot(24'h000000, 1'b1, 1'b1, 1'b0);
    repeat (14) u_h.dot(24'h00A5A5, 1'b0, 1'b1, 1'b1);
    u_h.w(8);
    chk("overflow", 1, povf);
    chk_on = 0;
    expq.delete();
    u_h.preset();
    chk("mode after reset pin", 2'h0, mode);
    chk("overflow after reset pin", 0, povf);
    chk("valid after reset pin", 0, pv);
    end_of_test();
  end
  // Watchdog against a hang
  initial begin
    repeat (60000) @(posedge sys_clk);
    fail_count++;
    end_of_test();
  end
endmodule // rgb_panel_port_tb
`default_nettype wire
